// [hbdi_pkg.sv]
// Operation
// R01 - Transmitter raises its DMA request when needing data
// R02 - Transmit request holds while FIFO needs bytes
// R03 - Host programs transmit byte count first
// R04 - Transmit blocks of 32, then remainder
// R05 - Transmit request drops after last block write
// R06 - Eight data, seven address, strobes, interrupt, DMA
// R07 - Strap selects separate strobes or strobe plus direction
// R08 - Strap low selects separate read/write strobes
// R09 - Address latch strobe captures multiplexed address
// R10 - Multiplexed bus: address pins tied to data
// R11 - Host does register command and status transfers
// R12 - FIFO data by DMA or by interrupt
// R13 - Interrupt-only use holds acknowledges high
// R14 - Without acknowledges, DMA uses ordinary register access
// R15 - Full variant two channels, reduced only B
// R16 - Receive request holds while FIFO needs emptying
// R17 - Receive request drops after last block read
// R18 - Acknowledge plus strobe accesses FIFO directly
package hbdi_pkg;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 7;
  localparam int TX_BLOCK    = 32;
  localparam int CNT_W       = 12;
  localparam logic [ADDR_W-1:0] FIFO_ADDR_A = 7'h00;
  localparam logic [ADDR_W-1:0] FIFO_ADDR_B = 7'h40;
  localparam logic [ADDR_W-1:0] FIFO_SPAN   = 7'h20;
endpackage

// [hbdi_if.sv]
`timescale 1ns/1ps
interface hbdi_if;
  import hbdi_pkg::*;
  logic [DATA_W-1:0] data_host;
  logic              data_host_oe;
  logic [DATA_W-1:0] data_dev;
  logic              data_dev_oe;
  logic [ADDR_W-1:0] addr;
  logic              ale;
  logic              rd_ds_n;
  logic              wr_rw;
  logic              cs_n;
  logic              irq;
  logic              tx_dma_request_a;
  logic              tx_dma_request_b;
  logic              rx_dma_request_a;
  logic              rx_dma_request_b;
  logic              dma_acknowledge_a_n;
  logic              dma_acknowledge_b_n;
  logic [DATA_W-1:0] data_bus;
  assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : '1);
  modport device (input data_bus, addr, ale, rd_ds_n, wr_rw, cs_n, dma_acknowledge_a_n, dma_acknowledge_b_n,
                  output data_dev, data_dev_oe, irq, tx_dma_request_a, tx_dma_request_b,
                  rx_dma_request_a, rx_dma_request_b);
  modport host (input data_bus, irq, tx_dma_request_a, tx_dma_request_b, rx_dma_request_a, rx_dma_request_b,
                output data_host, data_host_oe, addr, ale, rd_ds_n, wr_rw, cs_n,
                dma_acknowledge_a_n, dma_acknowledge_b_n);
endinterface

// [hbdi_device.sv]
`timescale 1ns/1ps
module hbdi_device
  import hbdi_pkg::*;
#(
  parameter bit TWO_CHANNELS = 1'b1
) (
  // Clock and control
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              bus_style_select,
  // Bus side
  hbdi_if.device                 bus,
  // Core side: register file
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic [ADDR_W-1:0]      reg_addr,
  output logic [DATA_W-1:0]      reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              core_irq,
  // Core side: per-channel FIFO ports, index 0 = A, 1 = B
  input  wire logic [1:0]        tx_start,
  input  wire logic [CNT_W-1:0]  tx_byte_count [2],
  output logic [1:0]             tx_push,
  output logic [DATA_W-1:0]      tx_data,
  input  wire logic [1:0]        rx_need,
  input  wire logic [5:0]        rx_block [2],
  output logic [1:0]             rx_pop,
  input  wire logic [DATA_W-1:0] rx_data [2]
);
  typedef struct packed {
    logic [1:0]        rd_s1, rd_s2, rd_s3;
    logic [1:0]        wr_s1, wr_s2, wr_s3;
    logic [1:0]        cs_s1, cs_s2;
    logic [1:0]        ack_a_s1, ack_a_s2;
    logic [1:0]        ack_b_s1, ack_b_s2;
    logic [1:0]        ale_s;
    logic [ADDR_W-1:0] addr_s1, addr_s2;
    logic [DATA_W-1:0] data_s1, data_s2;
    logic              style_s1;
    logic              style_q;
    logic [ADDR_W-1:0] latch_q;
    logic              latched_q;
    logic [1:0][CNT_W-1:0] tx_left_q;
    logic [1:0][5:0]   tx_blk_q;
    logic [1:0]        tx_req_q;
    logic [1:0][5:0]   rx_blk_q;
    logic [1:0]        rx_req_q;
    logic [DATA_W-1:0] dout_q;
    logic              doe_q;
    logic              wr_q, rd_q;
    logic [ADDR_W-1:0] ra_q;
    logic [DATA_W-1:0] wd_q;
    logic [1:0]        push_q, pop_q;
  } hbdi_dev_t;
  hbdi_dev_t s_q, s_d;

  function automatic logic [5:0] hbdi_min_blk(input logic [CNT_W-1:0] left);
    hbdi_min_blk = (left >= CNT_W'(TX_BLOCK)) ? 6'(TX_BLOCK) : left[5:0];
  endfunction

  logic       rd_act, wr_act, rd_end, wr_end, sel_ok;
  logic [1:0] ack_act;
  logic [ADDR_W-1:0] eff_addr;

  // Strobe decode per bus style, on synchronised pins
  always_comb begin
    if (!s_q.style_q) begin // R08
      rd_act = !s_q.rd_s2[0];
      wr_act = !s_q.wr_s2[0];
      rd_end = !s_q.rd_s3[0] && s_q.rd_s2[0];
      wr_end = !s_q.wr_s3[0] && s_q.wr_s2[0];
    end else begin // R07
      rd_act = !s_q.rd_s2[0] && s_q.wr_s2[0];
      wr_act = !s_q.rd_s2[0] && !s_q.wr_s2[0];
      rd_end = !s_q.rd_s3[0] && s_q.rd_s2[0] && s_q.wr_s3[0];
      wr_end = !s_q.rd_s3[0] && s_q.rd_s2[0] && !s_q.wr_s3[0];
    end
    ack_act = {!s_q.ack_b_s2[0], !s_q.ack_a_s2[0] && TWO_CHANNELS}; // R15
    sel_ok  = !s_q.cs_s2[0];
    eff_addr = s_q.latched_q ? s_q.latch_q : s_q.addr_s2; // R09
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.rd_s1 = {1'b0, bus.rd_ds_n};
    s_d.rd_s2 = s_q.rd_s1;
    s_d.rd_s3 = s_q.rd_s2;
    s_d.wr_s1 = {1'b0, bus.wr_rw};
    s_d.wr_s2 = s_q.wr_s1;
    s_d.wr_s3 = s_q.wr_s2;
    s_d.cs_s1 = {1'b0, bus.cs_n};
    s_d.cs_s2 = s_q.cs_s1;
    s_d.ack_a_s1 = {1'b0, bus.dma_acknowledge_a_n};
    s_d.ack_a_s2 = s_q.ack_a_s1;
    s_d.ack_b_s1 = {1'b0, bus.dma_acknowledge_b_n};
    s_d.ack_b_s2 = s_q.ack_b_s1;
    s_d.ale_s = {s_q.ale_s[0], bus.ale};
    s_d.addr_s1 = bus.addr;
    s_d.addr_s2 = s_q.addr_s1;
    s_d.data_s1 = bus.data_bus;
    s_d.data_s2 = s_q.data_s1;
    // Strap is a board pin, so it passes two flip-flops like the strobes
    s_d.style_s1 = bus_style_select;
    s_d.style_q  = s_q.style_s1;
    s_d.wr_q = 1'b0;
    s_d.rd_q = 1'b0;
    s_d.push_q = 2'b00;
    s_d.pop_q = 2'b00;
    // Address latch on strobe high; addr pins carry data lines when multiplexed
    if (s_q.ale_s[1]) begin // R09 R10
      s_d.latch_q   = s_q.addr_s2;
      s_d.latched_q = 1'b1;
    end
    // Read data drive: FIFO under acknowledge, else selected register
    s_d.doe_q = 1'b0;
    if (rd_act && ack_act[0]) begin // R18
      s_d.doe_q = 1'b1;
      s_d.dout_q = rx_data[0];
    end else if (rd_act && ack_act[1]) begin // R18
      s_d.doe_q = 1'b1;
      s_d.dout_q = rx_data[1];
    end else if (rd_act && sel_ok) begin // R11 R14
      s_d.doe_q = 1'b1;
      s_d.dout_q = reg_rdata;
    end
    // Per channel DMA engines
    for (int c = 0; c < 2; c++) begin
      logic dma_wr, dma_rd, fifo_hit;
      dma_wr = 1'b0;
      dma_rd = 1'b0;
      fifo_hit = (eff_addr >= (c == 0 ? FIFO_ADDR_A : FIFO_ADDR_B)) &&
                 (eff_addr < ((c == 0 ? FIFO_ADDR_A : FIFO_ADDR_B) + FIFO_SPAN));
      // Completed cycle hits FIFO by acknowledge, or by select and address
      if (ack_act[c] || (sel_ok && fifo_hit)) begin // R14 R18
        dma_wr = wr_end;
        dma_rd = rd_end;
      end
      if (c == 0 && !TWO_CHANNELS) begin // R15
        dma_wr = 1'b0;
        dma_rd = 1'b0;
      end
      s_d.push_q[c] = dma_wr;
      s_d.pop_q[c]  = dma_rd;
      // Transmit: load count, issue 32-byte blocks then remainder
      if (tx_start[c] && (TWO_CHANNELS || c == 1)) begin // R03 R04
        s_d.tx_left_q[c] = tx_byte_count[c];
        s_d.tx_blk_q[c]  = hbdi_min_blk(tx_byte_count[c]);
        s_d.tx_req_q[c]  = tx_byte_count[c] != '0; // R01
      end else if (dma_wr && s_q.tx_req_q[c]) begin
        s_d.tx_left_q[c] = s_q.tx_left_q[c] - CNT_W'(1);
        s_d.tx_blk_q[c]  = s_q.tx_blk_q[c] - 6'h01;
        if (s_q.tx_blk_q[c] == 6'h01) begin // R05
          s_d.tx_req_q[c] = 1'b0;
        end
      end else if (!s_q.tx_req_q[c] && s_q.tx_left_q[c] != '0 && !wr_act) begin // R02 R04
        s_d.tx_blk_q[c] = hbdi_min_blk(s_q.tx_left_q[c]);
        s_d.tx_req_q[c] = 1'b1;
      end
      // Receive: raise for a block, drop after its last read
      if (!s_q.rx_req_q[c] && rx_need[c] && rx_block[c] != 6'h00 && !rd_act &&
          (TWO_CHANNELS || c == 1)) begin // R16
        s_d.rx_req_q[c] = 1'b1;
        s_d.rx_blk_q[c] = rx_block[c];
      end else if (dma_rd && s_q.rx_req_q[c]) begin
        s_d.rx_blk_q[c] = s_q.rx_blk_q[c] - 6'h01;
        if (s_q.rx_blk_q[c] == 6'h01) begin // R17
          s_d.rx_req_q[c] = 1'b0;
        end
      end
    end
    // Register access whenever selected with no acknowledge, FIFO address hits included
    if (sel_ok && ack_act == 2'b00) begin // R11
      s_d.ra_q = eff_addr;
      s_d.wd_q = s_q.data_s2;
      s_d.wr_q = wr_end;
      s_d.rd_q = rd_end;
    end
    if (ack_act != 2'b00) begin
      s_d.wd_q = s_q.data_s2;
    end
  end

  // State register; clock enable low freezes all state, but reset still applies: it clears all but the rd, wr, cs and ack synchronisers, which load high
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.rd_s1 <= 2'b01;
      s_q.rd_s2 <= 2'b01;
      s_q.rd_s3 <= 2'b01;
      s_q.wr_s1 <= 2'b01;
      s_q.wr_s2 <= 2'b01;
      s_q.wr_s3 <= 2'b01;
      s_q.cs_s1 <= 2'b01;
      s_q.cs_s2 <= 2'b01;
      s_q.ack_a_s1 <= 2'b01;
      s_q.ack_a_s2 <= 2'b01;
      s_q.ack_b_s1 <= 2'b01;
      s_q.ack_b_s2 <= 2'b01;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign bus.data_dev         = s_q.dout_q; // R06
  assign bus.data_dev_oe      = s_q.doe_q;
  assign bus.irq              = core_irq; // R12
  assign bus.tx_dma_request_a = s_q.tx_req_q[0]; // R01
  assign bus.tx_dma_request_b = s_q.tx_req_q[1];
  assign bus.rx_dma_request_a = s_q.rx_req_q[0]; // R16
  assign bus.rx_dma_request_b = s_q.rx_req_q[1];
  assign reg_wr    = s_q.wr_q;
  assign reg_rd    = s_q.rd_q;
  assign reg_addr  = s_q.ra_q;
  assign reg_wdata = s_q.wd_q;
  assign tx_push   = s_q.push_q;
  assign tx_data   = s_q.wd_q;
  assign rx_pop    = s_q.pop_q;
endmodule

// [hbdi_host.sv]
`timescale 1ns/1ps
module hbdi_host
  import hbdi_pkg::*;
#(
  parameter int STROBE_CYC = 4
) (
  // Clock and control
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire logic              use_acknowledge,
  // Bus side
  hbdi_if.host                   bus,
  // User side: one access per request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic              req_dma,
  input  wire logic              req_chan_b,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   irq_seen
);
  typedef enum logic [1:0] {HB_IDLE, HB_SETUP, HB_STROBE, HB_HOLD} hbdi_hst_t;
  typedef struct packed {
    hbdi_hst_t         st;
    logic [7:0]        cnt;
    logic              wr, dma, chb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd, rd;
    logic              rsp;
    logic [1:0]        irq_s;
  } hbdi_host_t;
  hbdi_host_t s_q, s_d;
  logic ack_used;

  // Sequencer: setup, strobe for STROBE_CYC cycles, hold
  always_comb begin
    s_d = s_q;
    s_d.rsp = 1'b0;
    s_d.irq_s = {s_q.irq_s[0], bus.irq};
    unique case (s_q.st)
      HB_IDLE: begin
        if (req_valid) begin
          s_d.st = HB_SETUP;
          s_d.wr = req_write;
          s_d.dma = req_dma;
          s_d.chb = req_chan_b;
          s_d.addr = req_addr;
          s_d.wd = req_wdata;
        end
      end
      HB_SETUP: begin
        s_d.st = HB_STROBE;
        s_d.cnt = 8'(STROBE_CYC);
      end
      HB_STROBE: begin
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h01) begin
          s_d.st = HB_HOLD;
          s_d.rd = bus.data_bus;
        end
      end
      HB_HOLD: begin
        s_d.st = HB_IDLE;
        s_d.rsp = !s_q.wr;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Pin drive: separate strobes style, strap tied low by the board
  assign ack_used = s_q.dma && use_acknowledge && s_q.st != HB_IDLE;
  always_comb begin
    bus.ale     = s_q.st == HB_SETUP; // R09
    bus.addr    = s_q.addr; // R10
    bus.cs_n    = !(s_q.st != HB_IDLE && !ack_used); // R11 R14
    bus.rd_ds_n = !(s_q.st == HB_STROBE && !s_q.wr); // R08
    bus.wr_rw   = !(s_q.st == HB_STROBE && s_q.wr);
    bus.dma_acknowledge_a_n = !(ack_used && !s_q.chb); // R13 R18
    bus.dma_acknowledge_b_n = !(ack_used && s_q.chb);
    bus.data_host    = s_q.wd;
    bus.data_host_oe = s_q.wr && s_q.st != HB_IDLE;
  end

  assign req_ready = s_q.st == HB_IDLE;
  assign rsp_valid = s_q.rsp;
  assign rsp_rdata = s_q.rd;
  assign irq_seen  = s_q.irq_s[1]; // R12
endmodule

// [hbdi_monitor.sv]
`timescale 1ns/1ps
module hbdi_monitor (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // Strobes and data drivers
  input logic wr_rw,
  input logic rd_ds_n,
  input logic data_dev_oe,
  input logic data_host_oe,
  // DMA requests
  input logic tx_dma_request_a,
  input logic tx_dma_request_b,
  input logic rx_dma_request_a,
  input logic rx_dma_request_b
);
  logic [3:0] wr_age_q;
  logic [3:0] rd_age_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Cycles since each strobe was last low; saturates so long idle spans stay cheap
  always_ff @(posedge clock) begin
    wr_age_q <= (!rst_n) ? 4'hF : (!wr_rw) ? 4'h0 : (wr_age_q == 4'hF) ? wr_age_q : wr_age_q + 4'h1;
    rd_age_q <= (!rst_n) ? 4'hF : (!rd_ds_n) ? 4'h0 : (rd_age_q == 4'hF) ? rd_age_q : rd_age_q + 4'h1;
  end
  property p_txa_fall; $fell(tx_dma_request_a) |-> wr_age_q <= 4'hA; endproperty
  a_txa_fall: assert property (p_txa_fall) else $error("tx request a fell without a write");
  property p_txb_fall; $fell(tx_dma_request_b) |-> wr_age_q <= 4'hA; endproperty
  a_txb_fall: assert property (p_txb_fall) else $error("tx request b fell without a write");
  property p_rxa_fall; $fell(rx_dma_request_a) |-> rd_age_q <= 4'hA; endproperty
  a_rxa_fall: assert property (p_rxa_fall) else $error("rx request a fell without a read");
  property p_rxb_fall; $fell(rx_dma_request_b) |-> rd_age_q <= 4'hA; endproperty
  a_rxb_fall: assert property (p_rxb_fall) else $error("rx request b fell without a read");
  property p_txa_rise; $rose(tx_dma_request_a) |-> wr_rw; endproperty
  a_txa_rise: assert property (p_txa_rise) else $error("tx request a rose during a write");
  property p_rxa_rise; $rose(rx_dma_request_a) |-> rd_ds_n; endproperty
  a_rxa_rise: assert property (p_rxa_rise) else $error("rx request a rose during a read");
  property p_oe_read; data_dev_oe |-> rd_age_q <= 4'h7; endproperty
  a_oe_read: assert property (p_oe_read) else $error("device drives data outside a read");
  property p_one_drv; !(data_dev_oe && data_host_oe); endproperty
  a_one_drv: assert property (p_one_drv) else $error("both ends drive the data bus");
  // Main scenarios reached
  c_txa_fall: cover property ($fell(tx_dma_request_a));
  c_rxb_fall: cover property ($fell(rx_dma_request_b));
  c_oe_rise: cover property ($rose(data_dev_oe));
endmodule

// [host_bus_dma_interface_tb.sv]
`timescale 1ns/1ps
module host_bus_dma_interface_tb;
  import hbdi_pkg::*;
  logic              clock = 1'b0;
  logic              rst_n, use_acknowledge, req_valid, req_ready, req_write, req_dma, req_chan_b;
  logic [ADDR_W-1:0] req_addr, reg_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, reg_wdata, reg_rdata, tx_data, rd_val;
  logic              rsp_valid, irq_seen, reg_wr, reg_rd, core_irq, bus_style_select;
  logic [1:0]        tx_start, tx_push, rx_need, rx_pop;
  logic [CNT_W-1:0]  tx_byte_count [2];
  logic [5:0]        rx_block [2];
  logic [DATA_W-1:0] rx_data [2];
  int                num_errors, check_count;
  hbdi_if hbdi_if_inst ();
  // Requests then pulses, indexed by channel: pop 0-1, push 2-3, rx request 4-5, tx request 6-7
  wire [7:0] obs = {hbdi_if_inst.tx_dma_request_b, hbdi_if_inst.tx_dma_request_a,
    hbdi_if_inst.rx_dma_request_b, hbdi_if_inst.rx_dma_request_a, tx_push, rx_pop};
  hbdi_device hbdi_device_inst (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .bus_style_select(bus_style_select),
    .bus(hbdi_if_inst.device), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .core_irq(core_irq), .tx_start(tx_start), .tx_byte_count(tx_byte_count),
    .tx_push(tx_push), .tx_data(tx_data), .rx_need(rx_need), .rx_block(rx_block), .rx_pop(rx_pop),
    .rx_data(rx_data));
  hbdi_host hbdi_host_inst (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .use_acknowledge(use_acknowledge),
    .bus(hbdi_if_inst.host), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_dma(req_dma), .req_chan_b(req_chan_b), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq_seen(irq_seen));
  hbdi_monitor hbdi_monitor_inst (.clock(clock), .rst_n(rst_n), .wr_rw(hbdi_if_inst.wr_rw),
    .rd_ds_n(hbdi_if_inst.rd_ds_n), .data_dev_oe(hbdi_if_inst.data_dev_oe),
    .data_host_oe(hbdi_if_inst.data_host_oe), .tx_dma_request_a(hbdi_if_inst.tx_dma_request_a),
    .tx_dma_request_b(hbdi_if_inst.tx_dma_request_b), .rx_dma_request_a(hbdi_if_inst.rx_dma_request_a),
    .rx_dma_request_b(hbdi_if_inst.rx_dma_request_b));
  // 250 MHz
  always #2 clock = ~clock;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded wait so a missing pulse costs a mismatch, not a hang
  task automatic wait_obs(input int i, input logic v);
    for (int k = 0; k < 40 && obs[i] !== v; k++) @(negedge clock);
  endtask
  // One host access; request held until the edge that sees ready
  task automatic acc(input logic wr, input logic dma, input logic chb, input logic [6:0] a, input logic [7:0] d);
    req_write = wr;
    req_dma = dma;
    req_chan_b = chb;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    // Ready is looked at mid-cycle, so the next rising edge takes the request exactly once
    for (int k = 0; k < 40 && req_ready !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
    req_valid = 1'b0;
    for (int k = 0; k < 40 && !wr && rsp_valid !== 1'b1; k++) @(negedge clock);
    rd_val = rsp_rdata;
    for (int k = 0; k < 40 && req_ready !== 1'b1; k++) @(negedge clock);
  endtask
  task automatic t_reg;
    acc(1'b1, 1'b0, 1'b0, 7'h61, 8'h5A);
    for (int k = 0; k < 20 && reg_wr !== 1'b1; k++) @(negedge clock);
    check({reg_wr, reg_addr, reg_wdata}, {1'b1, 7'h61, 8'h5A});
    reg_rdata = 8'hC3;
    acc(1'b0, 1'b0, 1'b0, 7'h25, 8'h00);
    check(rd_val, 8'hC3);
    for (int k = 0; k < 20 && reg_rd !== 1'b1; k++) @(negedge clock);
    check({reg_rd, reg_addr}, {1'b1, 7'h25});
    core_irq = 1'b1;
    for (int k = 0; k < 10 && irq_seen !== 1'b1; k++) @(negedge clock);
    check({hbdi_if_inst.irq, irq_seen}, 2'h3);
    core_irq = 1'b0;
    // Strobe plus direction style: a low write pin alone is no write, a read still works
    bus_style_select = 1'b1;
    acc(1'b1, 1'b0, 1'b0, 7'h62, 8'hA5);
    for (int k = 0; k < 6 && reg_wr !== 1'b1; k++) @(negedge clock);
    check(reg_wr, 1'b0);
    acc(1'b0, 1'b0, 1'b0, 7'h26, 8'h00);
    check(rd_val, 8'hC3);
    for (int k = 0; k < 20 && reg_rd !== 1'b1; k++) @(negedge clock);
    check({reg_rd, reg_addr}, {1'b1, 7'h26});
    bus_style_select = 1'b0;
    $display("register test done");
  endtask
  task automatic t_tx(input int c, input int n, input logic ack);
    int left;
    int blk;
    left = n;
    use_acknowledge = ack;
    tx_byte_count[c] = n[CNT_W-1:0];
    tx_start[c] = 1'b1;
    @(negedge clock);
    tx_start[c] = 1'b0;
    while (left > 0) begin
      blk = (left > TX_BLOCK) ? TX_BLOCK : left;
      wait_obs(6 + c, 1'b1);
      for (int i = 0; i < blk; i++) begin
        check(obs[6 + c], 1'b1);
        acc(1'b1, 1'b1, c[0], c ? FIFO_ADDR_B : FIFO_ADDR_A, 8'h30 + i[7:0]);
        wait_obs(2 + c, 1'b1);
        check({obs[2 + c], tx_data}, {1'b1, 8'h30 + i[7:0]});
      end
      left -= blk;
      wait_obs(6 + c, 1'b0);
      check(obs[6 + c], 1'b0);
    end
    $display("transmit test done");
  endtask
  task automatic t_rx(input int c, input int size);
    use_acknowledge = 1'b1;
    rx_block[c] = size[5:0];
    rx_data[c] = 8'h80;
    rx_need[c] = 1'b1;
    wait_obs(4 + c, 1'b1);
    for (int i = 0; i < size; i++) begin
      check(obs[4 + c], 1'b1);
      acc(1'b0, 1'b1, c[0], c ? FIFO_ADDR_B : FIFO_ADDR_A, 8'h00);
      check(rd_val, 8'h80 + i[7:0]);
      wait_obs(c, 1'b1);
      check(obs[c], 1'b1);
      rx_data[c] = 8'h81 + i[7:0];
      if (i == size - 1) rx_need[c] = 1'b0;
    end
    wait_obs(4 + c, 1'b0);
    check(obs[4 + c], 1'b0);
    $display("receive test done");
  endtask
  initial begin
    {rst_n, use_acknowledge, req_valid, req_write, req_dma, req_chan_b, core_irq} = '0;
    {req_addr, req_wdata, reg_rdata, tx_start, rx_need} = '0;
    bus_style_select = 1'b0;
    tx_byte_count = '{default: '0};
    rx_block = '{default: '0};
    rx_data = '{default: '0};
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_reg;
    t_tx(0, 33, 1'b1);
    t_tx(1, 2, 1'b0);
    for (int i = 0; i < 4; i++) t_rx(i % 2, 32 >> i);
    test_done;
  end
  // Watchdog: the tests need about 4 us
  initial begin
    #100000;
    num_errors++;
    test_done;
  end
endmodule
